// >>> logic/ext_irq_pkg.sv
// constants and types shared by the external interrupt front end
package ext_irq_pkg;

    // ------------------------------------------------------------
    // clock rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 100_000_000;      // clk_i rate
    localparam int unsigned FC_HZ      = 100_000_000;      // fast clock, equal to clk_i
    localparam int unsigned CLK_PER_FC = CLK_HZ / FC_HZ;   // clk_i cycles per 1/fc

    // ------------------------------------------------------------
    // noise rejection times, in units of 1/fc
    // ------------------------------------------------------------
    localparam int unsigned REJ_NARROW_FC = 2;     // pins zero and five
    localparam int unsigned REJ_MID_FC    = 7;     // pins two, three, four
    localparam int unsigned REJ_SHORT_FC  = 15;    // pin one, filter select 1
    localparam int unsigned REJ_LONG_FC   = 63;    // pin one, filter select 0

    // agreeing samples needed after the synchroniser: one less than the
    // rejection time, since the first changed sample is not yet compared
    localparam logic [6:0] LEN_NARROW = 7'(REJ_NARROW_FC * CLK_PER_FC - 1);
    localparam logic [6:0] LEN_MID    = 7'(REJ_MID_FC * CLK_PER_FC - 1);
    localparam logic [6:0] LEN_SHORT  = 7'(REJ_SHORT_FC * CLK_PER_FC - 1);
    localparam logic [6:0] LEN_LONG   = 7'(REJ_LONG_FC * CLK_PER_FC - 1);

    // slow modes: two agreeing fs samples reject 1/fs and pass 3.5/fs
    localparam logic [6:0] SLOW_AGREE_TICKS = 7'h02;

    // pin samples shifted in before a filter may take its first level
    localparam logic [1:0] SYNC_FILL = 2'h3;

    // ------------------------------------------------------------
    // register map and control fields
    // ------------------------------------------------------------
    localparam int unsigned NUM_PINS     = 6;
    localparam logic [5:0]  CTRL_ADDR    = 6'h37;   // ext_irq_control
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_WMASK   = 8'hFE;   // bit 0 unused
    localparam int unsigned FILT_SEL_BIT = 7;
    localparam int unsigned FUNC_SEL_BIT = 6;
    localparam int unsigned EDGE4_LSB    = 4;
    localparam int unsigned EDGE3_BIT    = 3;
    localparam int unsigned EDGE2_BIT    = 2;
    localparam int unsigned EDGE1_BIT    = 1;

    typedef enum logic [1:0] {
        EDGE4_RISE  = 2'h0,
        EDGE4_FALL  = 2'h1,
        EDGE4_BOTH  = 2'h2,
        EDGE4_LEVEL = 2'h3
    } edge4_mode_t;

endpackage : ext_irq_pkg

// >>> logic/ext_irq_filter.sv
// digital noise filter and edge detector for one interrupt pin
`timescale 1ns/100ps
module ext_irq_filter (
    input  wire logic       clk_i,        // fast clock
    input  wire logic       resetn_i,     // synchronous reset, active low
    input  wire logic       pin_i,        // raw pin level
    input  wire logic       slow_i,       // slow or sleep mode
    input  wire logic       slow_tick_i,  // one pulse per fs period
    input  wire logic [6:0] fast_len_i,   // agreeing samples, fast modes
    output logic            level_o,      // filtered level
    output logic            rise_o,       // filtered rising edge pulse
    output logic            fall_o        // filtered falling edge pulse
);

    typedef struct packed {
        logic [2:0] sync;
        logic       filt;
        logic       primed;
        logic [1:0] fill;
        logic [6:0] cnt;
        logic       rise;
        logic       fall;
    } filt_state_t;

    filt_state_t st;
    filt_state_t next_st;
    logic [6:0]  need;
    logic        step;
    logic        agree;

    // ------------------------------------------------------------
    // filter
    // ------------------------------------------------------------
    // sync[0] feeds sync[1] only; a change counts once sync[1] and
    // sync[2] agree. the first agreeing sample after reset only primes
    // the level, so a pin already high reports no edge
    always_comb begin
        next_st      = st;
        next_st.sync = {st.sync[1:0], pin_i};
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        need         = slow_i ? ext_irq_pkg::SLOW_AGREE_TICKS : fast_len_i;
        step         = !slow_i || slow_tick_i;
        agree        = st.sync[1] == st.sync[2];
        if (!st.primed) begin
            // sync stages hold reset zeros at first; priming on those
            // would report a false rise on a pin that idles high
            if (st.fill != ext_irq_pkg::SYNC_FILL) begin
                next_st.fill = st.fill + 2'h1;
            end else if (agree) begin
                next_st.filt   = st.sync[2];
                next_st.primed = 1'b1;                         // [R14]
            end
        end else if (step) begin
            if (!agree || st.sync[2] == st.filt) begin
                next_st.cnt = 7'h00;                           // [R1]
            end else if ({1'b0, st.cnt} + 8'h01 >= {1'b0, need}) begin
                next_st.cnt  = 7'h00;
                next_st.filt = st.sync[2];
                next_st.rise = st.sync[2];
                next_st.fall = !st.sync[2];
            end else begin
                next_st.cnt = st.cnt + 7'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.filt;
    assign rise_o  = st.rise;
    assign fall_o  = st.fall;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fast_len_count: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R6]
        (rise_o || fall_o) && !$past(slow_i) |-> $past(st.cnt) + 7'h01 == $past(fast_len_i))
        else $error("fast edge without full agreeing count");

    a_slow_on_tick: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
        (rise_o || fall_o) && $past(slow_i) |-> $past(slow_tick_i) && $past(st.cnt) == 7'h01)
        else $error("slow edge off the fs tick or too early");

    a_no_edge_unprimed: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
        !$past(st.primed) |-> !rise_o && !fall_o)
        else $error("edge reported before the level was primed");

endmodule : ext_irq_filter

// >>> logic/external_interrupt_inputs.sv
// six-pin external interrupt front end with control register and latches
//
// Summary of operation
// R1 - six inputs, each noise filtered before edges
// R2 - control bit 6 picks port or pin zero
// R3 - software keeps shared port bit as input
// R4 - pin zero falling only, gated by bit 6
// R5 - request needs master, own flag, pin zero select
// R6 - pins zero, five: reject 2, pass 7 fc
// R7 - pin one rejects 15 or 63 fc
// R8 - bit 7: 0 gives 63, 1 gives 15
// R9 - pins two to four: reject 7 fc
// R10 - slow modes: reject 1/fs, pass 3.5/fs
// R11 - bits 1-3: 0 rising, 1 falling edge
// R12 - pin four: rise, fall, both, high level
// R13 - latch sets soon after a clean edge
// R14 - high level needs a rising edge after reset
// R15 - filter select change applies within 26 fc
// R16 - software disables interrupts while reconfiguring
// R17 - software masks false requests from shared pins
// R18 - control resets to zero, bit 0 unused
// R19 - control register sits at address 37h
// R20 - no read-modify-write on latches
// R21 - events set latches, held until cleared
`timescale 1ns/100ps
module external_interrupt_inputs (
    input  wire logic       clk_i,                       // fast clock, 100 MHz
    input  wire logic       resetn_i,                    // synchronous reset, active low
    input  wire logic [5:0] addr_i,                      // register address
    input  wire logic       wr_i,                        // register write strobe
    input  wire logic       rd_i,                        // register read strobe
    input  wire logic [7:0] wdata_i,                     // register write data
    output logic      [7:0] rdata_o,                     // register read data
    input  wire logic       irq_pin_zero_i,              // shared pin, falling edge
    input  wire logic       irq_pin_one_i,               // pin one
    input  wire logic       irq_pin_two_i,               // pin two
    input  wire logic       irq_pin_three_i,             // pin three
    input  wire logic       irq_pin_four_i,              // pin four
    input  wire logic       irq_pin_five_i,              // pin five, falling edge
    input  wire logic       slow_mode_i,                 // slow or sleep mode
    input  wire logic       slow_tick_i,                 // fs sample pulse
    input  wire logic       master_irq_enable_i,         // master enable
    input  wire logic [5:0] irq_enable_flags_i,          // individual enables
    input  wire logic [5:0] latch_clr_i,                 // clear pulses per latch
    output logic      [5:0] latch_o,                     // interrupt latches
    output logic      [5:0] irq_req_o,                   // enabled requests
    output logic            pin_zero_function_select_o   // 1: pin zero is interrupt
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] latch;
        logic       armed4;
        logic [7:0] rdata;
        logic [5:0] req;
    } top_state_t;

    top_state_t               st;
    top_state_t               next_st;
    logic [5:0]               pins;
    logic [5:0]               level;
    logic [5:0]               rise;
    logic [5:0]               fall;
    logic [5:0]               set_ev;
    logic [6:0]               len_one;
    ext_irq_pkg::edge4_mode_t mode4;
    logic                     func_sel;

    assign pins     = {irq_pin_five_i, irq_pin_four_i, irq_pin_three_i,
                       irq_pin_two_i, irq_pin_one_i, irq_pin_zero_i};
    assign func_sel = st.ctrl[ext_irq_pkg::FUNC_SEL_BIT];
    assign mode4    = ext_irq_pkg::edge4_mode_t'(st.ctrl[ext_irq_pkg::EDGE4_LSB +: 2]);

    // pin one rejection time follows bit 7 at once, well inside 26/fc
    assign len_one = st.ctrl[ext_irq_pkg::FILT_SEL_BIT] ?
                     ext_irq_pkg::LEN_SHORT : ext_irq_pkg::LEN_LONG;   // [R7] [R8] [R15]

    // ------------------------------------------------------------
    // noise filters, one per pin
    // ------------------------------------------------------------
    // each pin group has its own rejection time in the fast modes; the slow
    // modes all share the fs sample rule inside the filter
    generate
        for (genvar i = 0; i < ext_irq_pkg::NUM_PINS; i++) begin : g_pin
            localparam logic [6:0] FIXED_LEN =
                (i == 0 || i == 5) ? ext_irq_pkg::LEN_NARROW : ext_irq_pkg::LEN_MID;   // [R6] [R9]
            ext_irq_filter u_filter (
                .clk_i       (clk_i),
                .resetn_i    (resetn_i),
                .pin_i       (pins[i]),
                .slow_i      (slow_mode_i),                                // [R10]
                .slow_tick_i (slow_tick_i),
                .fast_len_i  ((i == 1) ? len_one : FIXED_LEN),             // [R1]
                .level_o     (level[i]),
                .rise_o      (rise[i]),
                .fall_o      (fall[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // edge qualification
    // ------------------------------------------------------------
    // pin zero counts only while it is selected as an interrupt input;
    // the high level on pin four waits for a rising edge after reset
    always_comb begin
        set_ev    = 6'h00;
        set_ev[0] = fall[0] && func_sel;                                        // [R4]
        set_ev[1] = st.ctrl[ext_irq_pkg::EDGE1_BIT] ? fall[1] : rise[1];       // [R11]
        set_ev[2] = st.ctrl[ext_irq_pkg::EDGE2_BIT] ? fall[2] : rise[2];       // [R11]
        set_ev[3] = st.ctrl[ext_irq_pkg::EDGE3_BIT] ? fall[3] : rise[3];       // [R11]
        set_ev[5] = fall[5];                                                    // [R6]
        unique case (mode4)
            ext_irq_pkg::EDGE4_RISE: begin
                set_ev[4] = rise[4];                                            // [R12]
            end
            ext_irq_pkg::EDGE4_FALL: begin
                set_ev[4] = fall[4];                                            // [R12]
            end
            ext_irq_pkg::EDGE4_BOTH: begin
                set_ev[4] = rise[4] || fall[4];                                 // [R12]
            end
            ext_irq_pkg::EDGE4_LEVEL: begin
                set_ev[4] = level[4] && st.armed4;                              // [R12] [R14]
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a set in the same cycle as a clear wins, so no event is lost
    always_comb begin
        next_st = st;
        if (rise[4]) begin
            next_st.armed4 = 1'b1;                                              // [R14]
        end
        next_st.latch = (st.latch & ~latch_clr_i) | set_ev;                     // [R21] [R13]
        if (wr_i && addr_i == ext_irq_pkg::CTRL_ADDR) begin
            next_st.ctrl = wdata_i & ext_irq_pkg::CTRL_WMASK;                   // [R19] [R2]
        end
        // reads outside this register return zero for the bus mux
        if (rd_i && addr_i == ext_irq_pkg::CTRL_ADDR) begin
            next_st.rdata = st.ctrl & ext_irq_pkg::CTRL_WMASK;                  // [R19]
        end else begin
            next_st.rdata = 8'h00;
        end
        next_st.req = st.latch & irq_enable_flags_i
                    & {6{master_irq_enable_i}}
                    & {5'h1F, func_sel};                                         // [R5]
    end

    // state register; reset leaves pin zero as a port and pins one to four on rising edges
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st      <= '0;
            st.ctrl <= ext_irq_pkg::CTRL_RESET;                                 // [R18] [R2]
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign rdata_o                    = st.rdata;
    assign latch_o                    = st.latch;
    assign irq_req_o                  = st.req;
    assign pin_zero_function_select_o = func_sel;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ctrl_reset_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R18]
        $rose(resetn_i) |-> st.ctrl == ext_irq_pkg::CTRL_RESET && !func_sel)
        else $error("control register not zero after reset");

    a_ctrl_write_addr: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R19]
        wr_i && addr_i == ext_irq_pkg::CTRL_ADDR
        |=> st.ctrl == ($past(wdata_i) & ext_irq_pkg::CTRL_WMASK))
        else $error("control write at 37h not stored");

    a_ctrl_read_back: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R19]
        rd_i && addr_i == ext_irq_pkg::CTRL_ADDR && !wr_i
        |=> rdata_o == st.ctrl && !rdata_o[0])
        else $error("control read does not match register");

    a_zero_port_mode: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
        $rose(latch_o[0]) |-> $past(func_sel) && $past(fall[0]))
        else $error("pin zero latch set outside interrupt mode");

    a_req_gate_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
        irq_req_o[0] |-> $past(latch_o[0]) && $past(master_irq_enable_i)
                        && $past(irq_enable_flags_i[0]) && $past(func_sel))
        else $error("pin zero request without all enables");

    a_req_no_master: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
        !master_irq_enable_i |=> irq_req_o == 6'h00)
        else $error("request raised with master enable low");

    a_edge_one_sel: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
        $rose(latch_o[1]) |-> ($past(st.ctrl[ext_irq_pkg::EDGE1_BIT]) ? $past(fall[1]) : $past(rise[1])))
        else $error("pin one latched on the wrong edge");

    a_four_level_arm: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
        $rose(latch_o[4]) && $past(mode4) == ext_irq_pkg::EDGE4_LEVEL |-> $past(st.armed4))
        else $error("level request before a rising edge");

    a_four_both_edge: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
        mode4 == ext_irq_pkg::EDGE4_BOTH && fall[4] && !wr_i |=> latch_o[4])
        else $error("both-edge mode missed a falling edge");

    a_latch_holds: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R21]
        latch_o[2] && !latch_clr_i[2] |=> latch_o[2] [*1] ##0 !$fell(latch_o[2]))
        else $error("latch dropped without a clear");

    a_set_over_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R21]
        (set_ev & latch_clr_i) != 6'h00 |=> (latch_o & $past(set_ev)) == $past(set_ev))
        else $error("clear beat a simultaneous set");

    a_sel_len_apply: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R15]
        $changed(st.ctrl[ext_irq_pkg::FILT_SEL_BIT]) |-> g_pin[1].u_filter.fast_len_i ==
        (st.ctrl[ext_irq_pkg::FILT_SEL_BIT] ? ext_irq_pkg::LEN_SHORT : ext_irq_pkg::LEN_LONG))
        else $error("pin one rejection time not updated");

    a_latch_soon: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R13]
        fall[5] |=> latch_o[5])
        else $error("pin five latch late after filtered edge");

    a_req_follows_latch: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
        latch_o[3] && master_irq_enable_i && irq_enable_flags_i[3] |=> irq_req_o[3])
        else $error("pin three request missing with all enables");

    a_sel_from_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R2]
        wr_i && addr_i == ext_irq_pkg::CTRL_ADDR
        |=> pin_zero_function_select_o == $past(wdata_i[ext_irq_pkg::FUNC_SEL_BIT]))
        else $error("pin zero function select does not follow bit 6");

    a_level_sets_latch: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
        mode4 == ext_irq_pkg::EDGE4_LEVEL && level[4] && st.armed4 |=> latch_o[4])
        else $error("armed high level did not set the pin four latch");

    a_edge_two_sel: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
        $rose(latch_o[2]) |-> ($past(st.ctrl[ext_irq_pkg::EDGE2_BIT]) ? $past(fall[2]) : $past(rise[2])))
        else $error("pin two latched on the wrong edge");

endmodule : external_interrupt_inputs

// >>> testbench/irq_pin_source.sv
// partner model: signal sources on the six interrupt pins
`timescale 1ns/100ps
module irq_pin_source (
    input  wire logic       clk_i,  // bench clock
    output logic      [5:0] pins_o  // pin levels
);
    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // lines idle high as if pulled up
    initial pins_o = 6'h3F;

    // shared pin is only ever driven as an input, never turned round
    task automatic set_pin(input int pin, input logic lvl);
        @(negedge clk_i);
        @(posedge clk_i);
        #1;
        pins_o[pin] = lvl;
    endtask : set_pin
endmodule : irq_pin_source

// >>> testbench/test_external_interrupt_inputs.sv
// self-checking bench for the external interrupt front end
`timescale 1ns/100ps
module test_external_interrupt_inputs;
    logic       clk_i;
    logic       resetn_i;
    logic [5:0] addr_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic [5:0] pins;
    logic       slow_mode_i;
    logic       slow_tick_i = 1'b0;
    logic [2:0] tick_cnt = 3'h0;
    logic       master_irq_enable_i;
    logic [5:0] irq_enable_flags_i;
    logic [5:0] latch_clr_i;
    logic [5:0] latch_o;
    logic [5:0] irq_req_o;
    logic       sel_o;
    logic [7:0] ctrl;
    logic [7:0] d;
    int         fails;
    int         tests_run;
    int         seed;

    irq_pin_source i_irq_pin_source (.clk_i(clk_i), .pins_o(pins));

    external_interrupt_inputs i_external_interrupt_inputs (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .irq_pin_zero_i(pins[0]), .irq_pin_one_i(pins[1]), .irq_pin_two_i(pins[2]),
        .irq_pin_three_i(pins[3]), .irq_pin_four_i(pins[4]), .irq_pin_five_i(pins[5]),
        .slow_mode_i(slow_mode_i), .slow_tick_i(slow_tick_i),
        .master_irq_enable_i(master_irq_enable_i), .irq_enable_flags_i(irq_enable_flags_i),
        .latch_clr_i(latch_clr_i), .latch_o(latch_o), .irq_req_o(irq_req_o),
        .pin_zero_function_select_o(sel_o));

    // ------------------------------------------------------------
    // clock and slow sample pulse, one every 8 cycles
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        tick_cnt    <= tick_cnt + 3'h1;
        slow_tick_i <= (tick_cnt == 3'h7);
    end

    // ------------------------------------------------------------
    // helpers and expectations
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // shortest pulse that passes, in cycles
    function automatic int rej_len(input int pin, input logic [7:0] c);
        if (pin == 0 || pin == 5)
            return ext_irq_pkg::REJ_NARROW_FC;
        if (pin == 1)
            return c[7] ? ext_irq_pkg::REJ_SHORT_FC : ext_irq_pkg::REJ_LONG_FC;
        return ext_irq_pkg::REJ_MID_FC;
    endfunction : rej_len

    // {falling counts, rising counts}; level mode behaves as falling for a low pulse
    function automatic logic [1:0] edges(input int pin, input logic [7:0] c);
        case (pin)
            0: return {c[6], 1'b0};
            5: return 2'b10;
            4: return (c[5:4] == 2'h2) ? 2'b11 : {c[4], ~c[4]};
            default: return {c[pin], ~c[pin]};
        endcase
    endfunction : edges

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] v);
        addr_i  = a;
        wdata_i = v;
        wr_i    = 1'b1;
        step(1);
        wr_i = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, output logic [7:0] v);
        addr_i = a;
        rd_i   = 1'b1;
        step(1);
        rd_i = 1'b0;
        v    = rdata_o;
    endtask : reg_rd

    // enables off while rewriting, plain write only, then random enables
    task automatic set_ctrl(input logic [7:0] v);
        master_irq_enable_i = 1'b0;
        reg_wr(6'h37, v);
        ctrl = v & 8'hFE;
        {master_irq_enable_i, irq_enable_flags_i} = 7'($random(seed));
    endtask : set_ctrl

    // low pulse of len cycles; mid: check and clear at the pulse's end
    task automatic hit(input int pin, input int len, input int settle, input bit mid, input bit acc);
        logic [1:0] e;
        logic       l;
        e = edges(pin, ctrl);
        i_irq_pin_source.set_pin(pin, 1'b0);
        step(len - 1);
        if (mid) begin
            chk(latch_o[pin], e[1] & acc);
            latch_clr_i = 6'(1 << pin);
        end
        i_irq_pin_source.set_pin(pin, 1'b1);
        latch_clr_i = 6'h00;
        step(settle);
        l = (mid ? 1'b0 : e[1] & acc) | (e[0] & acc);
        chk(latch_o[pin], l);
        chk(irq_req_o[pin], l & master_irq_enable_i & irq_enable_flags_i[pin] & (pin != 0 || ctrl[6]));
        latch_clr_i = 6'(1 << pin);
        step(1);
        latch_clr_i = 6'h00;
    endtask : hit

    task automatic do_reset();
        resetn_i = 1'b0;
        step(10);
        resetn_i = 1'b1;
    endtask : do_reset

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // watchdog, far beyond the expected run length
    initial begin
        #300000;
        fails++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int p;
        int r;
        int len;
        logic [7:0] c;
        seed = 32'hE96C;
        {resetn_i, addr_i, wr_i, rd_i, wdata_i, slow_mode_i} = '0;
        {master_irq_enable_i, irq_enable_flags_i, latch_clr_i, ctrl} = '0;
        do_reset();
        chk({latch_o, sel_o}, 8'h00);
        reg_rd(6'h37, d);
        chk(d, 8'h00);
        set_ctrl(8'hFF);
        reg_rd(6'h37, d);
        chk(d, 8'hFE);
        chk(sel_o, 1'b1);
        reg_wr(6'h36, 8'h00);
        reg_rd(6'h36, d);
        chk(d, 8'h00);
        reg_rd(6'h37, d);
        chk(d, 8'hFE);
        // boundary lengths on every pin, both pin one filter selects
        for (int k = 0; k < 6; k++) begin
            set_ctrl(8'hDE);
            hit(k, rej_len(k, ctrl) - 1, 80, 1'b0, 1'b0);
            hit(k, rej_len(k, ctrl), 80, 1'b0, 1'b1);
        end
        set_ctrl(8'h5E);
        hit(1, 62, 80, 1'b0, 1'b0);
        hit(1, 63, 80, 1'b0, 1'b1);
        // random pins, modes, lengths and enables
        for (int k = 0; k < 24; k++) begin
            p = unsigned'($random(seed)) % 6;
            c = 8'($random(seed));
            if (c[5:4] == 2'h3)
                c[5] = 1'b0;
            set_ctrl(c);
            r = rej_len(p, ctrl);
            if ($random(seed) & 1)
                len = 1 + unsigned'($random(seed)) % (r - 1);
            else
                len = r + 5 + unsigned'($random(seed)) % 16;
            hit(p, len, 80, len > r, len >= r);
        end
        // slow mode: half an fs period rejected, 3.5 passes
        set_ctrl(8'hDE);
        slow_mode_i = 1'b1;
        step(16);
        hit(5, 4, 40, 1'b0, 1'b0);
        hit(2, 28, 48, 1'b0, 1'b1);
        slow_mode_i = 1'b0;
        // level mode armed only by a rising edge after reset
        do_reset();
        set_ctrl(8'h70);
        step(30);
        chk(latch_o[4], 1'b0);
        hit(4, 20, 40, 1'b0, 1'b1);
        chk(latch_o[4], 1'b1);
        final_report();
    end
endmodule : test_external_interrupt_inputs
